// >>> bench/adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_cfg.svh"

module adc_conversion_sequencer_tb_top;
   import acs_pkg::*;

   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] rb;
      logic [2:0] pvr;
      logic [3:0] ch;
   } acs_row_t;

   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic comparator_high = 1'b0;
   logic converter_power_on;
   logic [3:0] input_channel_select;
   logic analog_input_valid;
   logic reference_use_supply;
   logic sample_enable;
   acs_code_t dac_code;
   logic conversion_irq_pulse;
   logic conversion_irq_request;
   logic [7:0] vin = 8'h00;
   int num_errors = 0;
   int compares = 0;
   int samp_cnt = 0;
   int conv_cnt = 0;
   int irq_cnt = 0;
   logic [31:0] q;
   acs_row_t rows [9];

   // The one slave's ready is the bus ready.
   assign hready = hreadyout;

   acs_top dut (
      .clk(clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .comparator_high(comparator_high), .converter_power_on(converter_power_on),
      .input_channel_select(input_channel_select), .analog_input_valid(analog_input_valid),
      .reference_use_supply(reference_use_supply), .sample_enable(sample_enable), .dac_code(dac_code),
      .conversion_irq_pulse(conversion_irq_pulse), .conversion_irq_request(conversion_irq_request)
   );

   always #10 clk = ~clk;

   // Ideal comparator, so the finished code equals the input level.
   always @(posedge clk) begin
      comparator_high <= (vin >= dac_code);
   end

   always @(posedge clk) begin
      if (sample_enable === 1'b1) samp_cnt++;
      if (dac_code !== 8'h00) conv_cnt++;
      if (conversion_irq_pulse === 1'b1) irq_cnt++;
   end

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         tally_and_finish();
      end
   endtask : wait_ready

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      r = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, {24'h0, d}, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask : rd

   // Polls busy; the first read waits out the trigger latency after the start write.
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(posedge clk);
      do begin
         rd(`ACS_OFF_CTRL_A, q);
         n++;
      end while (q[`ACS_A_BUSY] !== 1'b0 && n < 2000);
      if (n >= 2000) begin
         num_errors++;
         tally_and_finish();
      end
   endtask : wait_idle

   task automatic run_conv(input logic [7:0] v, input logic [2:0] div, input logic retrig);
      int p;
      p = 1 << div;
      vin <= v;
      wr(`ACS_OFF_CTRL_B, 8'h08 | div);
      wr(`ACS_OFF_CTRL_A, 8'h20);
      wr(`ACS_OFF_CTRL_A, 8'ha0);
      samp_cnt = 0;
      conv_cnt = 0;
      irq_cnt = 0;
      wr(`ACS_OFF_CTRL_A, 8'h20);
      if (retrig) begin
         wr(`ACS_OFF_CTRL_A, 8'ha0);
         wr(`ACS_OFF_CTRL_A, 8'h20);
      end
      wait_idle();
      rd(`ACS_OFF_RESULT, q);
      check(q, {24'h0, v});
      check(samp_cnt >= 3 * p && samp_cnt <= 4 * p + 1, 1);
      check(conv_cnt >= 8 * p - 1 && conv_cnt <= 8 * p + 1, 1);
      check(irq_cnt, 1);
      $display("conversion of %h at divider %0d done", v, div);
   endtask : run_conv

   initial begin
      rows[0] = '{`ACS_OFF_CTRL_B, 8'h00, 8'h00, 3'b000, 4'h0};
      rows[1] = '{`ACS_OFF_CTRL_B, 8'h08, 8'h08, 3'b001, 4'h0};
      rows[2] = '{`ACS_OFF_CTRL_B, 8'h10, 8'h10, 3'b000, 4'h0};
      rows[3] = '{`ACS_OFF_CTRL_B, 8'h1b, 8'h1b, 3'b000, 4'h0};
      rows[4] = '{`ACS_OFF_CTRL_A, 8'h20, 8'h20, 3'b110, 4'h0};
      rows[5] = '{`ACS_OFF_CTRL_A, 8'h29, 8'h29, 3'b110, 4'h9};
      rows[6] = '{`ACS_OFF_CTRL_A, 8'h2a, 8'h2a, 3'b100, 4'ha};
      rows[7] = '{`ACS_OFF_CTRL_A, 8'h0f, 8'h0f, 3'b000, 4'hf};
      rows[8] = '{`ACS_OFF_CTRL_A, 8'h3f, 8'h2f, 3'b100, 4'hf};
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Reset values, and an unmapped place that ignores writes.
      wr(8'h10, 8'hff);
      for (int i = 0; i < 5; i++) begin
         rd(8'(i * 4), q);
         check(q, 32'h0);
      end
      check({converter_power_on, sample_enable, dac_code}, 10'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         repeat (2) @(posedge clk);
         check({converter_power_on, analog_input_valid, reference_use_supply}, rows[i].pvr);
         check(input_channel_select, rows[i].ch);
         rd(rows[i].a, q);
         check(q, {24'h0, rows[i].rb});
      end
      $display("register table test done");
      // A start bit held high does not trigger; the falling edge does.
      wr(`ACS_OFF_CTRL_A, 8'ha0);
      repeat (40) @(posedge clk);
      rd(`ACS_OFF_CTRL_A, q);
      check(q, 32'ha0);
      vin <= 8'h3c;
      wr(`ACS_OFF_CTRL_A, 8'h20);
      rd(`ACS_OFF_CTRL_A, q);
      check(q[`ACS_A_BUSY], 1'b1);
      wait_idle();
      rd(`ACS_OFF_RESULT, q);
      check(q, 32'h3c);
      $display("start pulse test done");
      // Interrupt request follows the flag and the global enable.
      wr(`ACS_OFF_IRQ, 8'h00);
      wr(`ACS_OFF_IRQ, 8'h05);
      run_conv(8'h5a, 3'h3, 1'b0);
      check(conversion_irq_request, 1'b1);
      rd(`ACS_OFF_IRQ, q);
      check(q, 32'h07);
      wr(`ACS_OFF_IRQ, 8'h05);
      repeat (2) @(posedge clk);
      check(conversion_irq_request, 1'b0);
      wr(`ACS_OFF_IRQ, 8'h01);
      run_conv(8'hff, 3'h4, 1'b0);
      check(conversion_irq_request, 1'b0);
      rd(`ACS_OFF_IRQ, q);
      check(q, 32'h03);
      $display("interrupt test done");
      // A second start pulse during a conversion is ignored.
      run_conv(8'h00, 3'h3, 1'b1);
      repeat (40) @(posedge clk);
      rd(`ACS_OFF_CTRL_A, q);
      check(q[`ACS_A_BUSY], 1'b0);
      run_conv(8'h81, 3'h7, 1'b0);
      // Clearing the enable mid-conversion aborts and keeps the old result.
      vin <= 8'h11;
      wr(`ACS_OFF_CTRL_A, 8'ha0);
      wr(`ACS_OFF_CTRL_A, 8'h20);
      repeat (300) @(posedge clk);
      wr(`ACS_OFF_CTRL_A, 8'h00);
      repeat (3) @(posedge clk);
      check({converter_power_on, analog_input_valid, sample_enable, dac_code}, 11'h0);
      rd(`ACS_OFF_CTRL_A, q);
      check(q, 32'h00);
      rd(`ACS_OFF_RESULT, q);
      check(q, 32'h81);
      $display("abort test done");
      // A second reset in mid-conversion clears the registers and busy again.
      wr(`ACS_OFF_CTRL_A, 8'ha0);
      wr(`ACS_OFF_CTRL_A, 8'h20);
      repeat (20) @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      check({converter_power_on, sample_enable, dac_code, conversion_irq_request}, 11'h0);
      rd(`ACS_OFF_CTRL_A, q);
      check(q, 32'h0);
      rd(`ACS_OFF_IRQ, q);
      check(q, 32'h0);
      rd(`ACS_OFF_RESULT, q);
      check(q, 32'h0);
      rd(`ACS_OFF_CTRL_B, q);
      check(q, 32'h0);
      $display("second reset test done");
      tally_and_finish();
   end
endmodule : adc_conversion_sequencer_tb_top

`default_nettype wire

// >>> include/acs_cfg.svh
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Register byte offsets on the AHB-Lite bus.
`define ACS_OFF_CTRL_A 8'h00
`define ACS_OFF_CTRL_B 8'h04
`define ACS_OFF_RESULT 8'h08
`define ACS_OFF_IRQ 8'h0c

// Field positions in converter_control_a.
`define ACS_A_START 7
`define ACS_A_BUSY 6
`define ACS_A_ENABLE 5
`define ACS_A_CHAN_LSB 0
`define ACS_A_CHAN_MSB 3

// Field positions in converter_control_b.
`define ACS_B_DIV_LSB 0
`define ACS_B_DIV_MSB 2
`define ACS_B_REF_LSB 3
`define ACS_B_REF_MSB 4

// Field positions in the interrupt register.
`define ACS_I_IRQ_EN 0
`define ACS_I_IRQ_FLAG 1
`define ACS_I_GLOBAL_EN 2

// Reset values.
`define ACS_RST_CTRL_A 8'h00
`define ACS_RST_CTRL_B 8'h00
`define ACS_RST_RESULT 8'h00

// Timing counts in converter clock periods.
`define ACS_SAMPLE_TICKS 4'h4
`define ACS_CONVERT_TICKS 4'h8
`define ACS_TOTAL_TICKS 4'hc

// Channel and reference decoding.
`define ACS_CHAN_LAST 4'h9
`define ACS_REF_SUPPLY 2'h1

`endif

// >>> include/acs_pkg.sv
`default_nettype none

package acs_pkg;

   // Gray coded along idle, sample, convert.
   typedef enum logic [1:0] {
      ACS_IDLE = 2'h0,
      ACS_SAMPLE = 2'h1,
      ACS_CONVERT = 2'h3
   } acs_state_t;

   typedef logic [7:0] acs_code_t;

endpackage : acs_pkg

`default_nettype wire

// >>> rtl/acs_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none

module acs_clkdiv #(
   parameter int CNT_W = 7
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Divider control and enable output.
   input wire logic [2:0] div_sel,
   output logic tick
);

   logic [CNT_W-1:0] cnt_reg;

   function automatic logic [CNT_W-1:0] div_mask(input logic [2:0] sel);
      logic [CNT_W:0] one;
      one = {{CNT_W{1'b0}}, 1'b1};
      div_mask = CNT_W'((one << sel) - one);
   endfunction : div_mask

   // Free-running so a slow divider setting never needs a restart.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   assign tick = &(cnt_reg | ~div_mask(div_sel));

endmodule : acs_clkdiv

`default_nettype wire

// >>> rtl/acs_top.sv
// Overview of operation
// - A conversion takes 4 converter clocks sampling then 8 converting, 12 in total.
// - Once started, the sequencer runs alone and never stalls the bus.
// - The selected channel is routed to the converter; software sets the pin first.
// - A conversion starts only after the start bit goes high then low.
// - Busy reads one during a conversion and zero after, result then updated.
// - Clearing the enable powers down all converter circuitry; channel and reference selects still follow the registers.
// - The result is an unsigned 8-bit code, all ones at full scale.
// - One step equals the active reference divided by 256.
// - Code transitions sit half a step early, the last one and a half below.
// - Writing 20h to control A enables the converter on channel zero.
// - Divider codes 000 to 111 divide the system clock by 1 to 128.
// - Channel codes 0 to 9 select inputs; 10 to 15 leave the input floating.
// - Completion sets the request flag and pulses the internal interrupt signal.
// - Reference code 01 uses the supply; every other code the external pin.
`timescale 1ns/1ps
`default_nettype none
`include "acs_cfg.svh"

module acs_top (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Analog front end control.
   input wire logic comparator_high,
   output logic converter_power_on,
   output logic [3:0] input_channel_select,
   output logic analog_input_valid,
   output logic reference_use_supply,
   output logic sample_enable,
   output acs_pkg::acs_code_t dac_code,
   // Interrupt controller side.
   output logic conversion_irq_pulse,
   output logic conversion_irq_request
);
   import acs_pkg::*;

   logic rst_sync1_reg;
   logic rst_n;
   logic tick;
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   logic start_reg;
   logic start_prev_reg;
   logic converter_enable_reg;
   logic [3:0] chan_reg;
   logic [2:0] div_reg;
   logic [1:0] ref_reg;
   logic irq_en_reg;
   logic irq_flag_reg;
   logic global_en_reg;
   acs_code_t result_reg;
   acs_code_t trial_reg;
   acs_state_t state_reg;
   logic [2:0] bit_reg;
   logic [3:0] phase_reg;
   logic [2:0] cmp_sync_reg;
   logic cmp_reg;
   logic trigger;
   logic done;
   logic addr_phase;
   acs_code_t decided;

   // Reset is asserted at once but released through two flops.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_n <= rst_sync1_reg;
      end
   end

   acs_clkdiv #(.CNT_W(7)) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .div_sel(div_reg),
      .tick(tick)
   );

   // Zero-wait slave, so the processor is never held by a conversion.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel && htrans[1] && hready;

   function automatic logic [7:0] reg_read(input logic [7:0] a);
      case (a)
         `ACS_OFF_CTRL_A: reg_read = {start_reg, state_reg != ACS_IDLE, converter_enable_reg, 1'b0, chan_reg};
         `ACS_OFF_CTRL_B: reg_read = {3'h0, ref_reg, div_reg};
         `ACS_OFF_RESULT: reg_read = result_reg;
         `ACS_OFF_IRQ: reg_read = {5'h0, global_en_reg, irq_flag_reg, irq_en_reg};
         default: reg_read = 8'h00;
      endcase
   endfunction : reg_read

   // Read data is captured at the address phase; single transfers only.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         if (addr_phase) begin
            addr_reg <= haddr;
            hrdata <= {24'h0, reg_read(haddr)};
         end
      end
   end

   // Control A writes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_reg <= 1'(`ACS_RST_CTRL_A >> `ACS_A_START);
         converter_enable_reg <= 1'b0;
         chan_reg <= 4'h0;
      end else if (wr_pend_reg && addr_reg == `ACS_OFF_CTRL_A) begin
         start_reg <= hwdata[`ACS_A_START];
         converter_enable_reg <= hwdata[`ACS_A_ENABLE];
         chan_reg <= hwdata[`ACS_A_CHAN_MSB:`ACS_A_CHAN_LSB];
      end
   end

   // Control B writes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 3'h0;
         ref_reg <= 2'h0;
      end else if (wr_pend_reg && addr_reg == `ACS_OFF_CTRL_B) begin
         div_reg <= hwdata[`ACS_B_DIV_MSB:`ACS_B_DIV_LSB];
         ref_reg <= hwdata[`ACS_B_REF_MSB:`ACS_B_REF_LSB];
      end
   end

   // Interrupt enables and request flag; completion wins over a clear.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_reg <= 1'b0;
         global_en_reg <= 1'b0;
         irq_flag_reg <= 1'b0;
      end else begin
         if (wr_pend_reg && addr_reg == `ACS_OFF_IRQ) begin
            irq_en_reg <= hwdata[`ACS_I_IRQ_EN];
            global_en_reg <= hwdata[`ACS_I_GLOBAL_EN];
         end
         if (done) begin
            irq_flag_reg <= 1'b1;
         end else if (wr_pend_reg && addr_reg == `ACS_OFF_IRQ) begin
            irq_flag_reg <= hwdata[`ACS_I_IRQ_FLAG];
         end
      end
   end

   // The start bit only counts once it has been released again.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_prev_reg <= 1'b0;
      end else begin
         start_prev_reg <= start_reg;
      end
   end
   assign trigger = start_prev_reg && !start_reg && converter_enable_reg;

   // Comparator pin: three flops, a change counts when the last two agree.
   // Divider settings under eight system clocks per tick outrun this latency.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_sync_reg <= 3'h0;
         cmp_reg <= 1'b0;
      end else begin
         cmp_sync_reg <= {cmp_sync_reg[1:0], comparator_high};
         if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
            cmp_reg <= cmp_sync_reg[2];
         end
      end
   end

   // Binary search: keep the trial bit if the input is at or above it.
   always_comb begin
      decided = trial_reg;
      if (!cmp_reg) begin
         decided[bit_reg] = 1'b0;
      end
   end

   assign done = state_reg == ACS_CONVERT && tick && bit_reg == 3'h0 && converter_enable_reg;

   // Sequencer; sampling starts on the trigger and disabling returns to idle at once, other moves wait for converter clock ticks.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ACS_IDLE;
         phase_reg <= 4'h0;
         bit_reg <= 3'h7;
         trial_reg <= 8'h00;
      end else if (!converter_enable_reg) begin
         state_reg <= ACS_IDLE;
         phase_reg <= 4'h0;
         trial_reg <= 8'h00;
      end else begin
         case (state_reg)
            ACS_IDLE: begin
               if (trigger) begin
                  state_reg <= ACS_SAMPLE;
                  phase_reg <= 4'h0;
               end
            end
            ACS_SAMPLE: begin
               if (tick) begin
                  if (phase_reg == `ACS_SAMPLE_TICKS - 4'h1) begin
                     state_reg <= ACS_CONVERT;
                     bit_reg <= 3'h7;
                     trial_reg <= 8'h80;
                     phase_reg <= 4'h0;
                  end else begin
                     phase_reg <= phase_reg + 4'h1;
                  end
               end
            end
            ACS_CONVERT: begin
               if (tick) begin
                  phase_reg <= phase_reg + 4'h1;
                  if (bit_reg == 3'h0) begin
                     state_reg <= ACS_IDLE;
                     trial_reg <= 8'h00;
                  end else begin
                     trial_reg <= decided | (8'h01 << (bit_reg - 3'h1));
                     bit_reg <= bit_reg - 3'h1;
                  end
               end
            end
            default: begin
               state_reg <= ACS_IDLE;
            end
         endcase
      end
   end

   // Result changes only at completion; disabling leaves it intact.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= `ACS_RST_RESULT;
      end else if (done) begin
         result_reg <= decided;
      end
   end

   // Internal interrupt pulse, one cycle per completion.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conversion_irq_pulse <= 1'b0;
      end else begin
         conversion_irq_pulse <= done;
      end
   end

   // Front end drive; power, input valid, sampling and DAC code go quiet while disabled, channel and reference still follow the registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_power_on <= 1'b0;
         input_channel_select <= 4'h0;
         analog_input_valid <= 1'b0;
         reference_use_supply <= 1'b0;
         sample_enable <= 1'b0;
         dac_code <= 8'h00;
         conversion_irq_request <= 1'b0;
      end else begin
         converter_power_on <= converter_enable_reg;
         input_channel_select <= chan_reg;
         analog_input_valid <= converter_enable_reg && chan_reg <= `ACS_CHAN_LAST;
         reference_use_supply <= ref_reg == `ACS_REF_SUPPLY;
         sample_enable <= converter_enable_reg && state_reg == ACS_SAMPLE;
         dac_code <= trial_reg;
         conversion_irq_request <= irq_flag_reg && irq_en_reg && global_en_reg;
      end
   end

   // Checking logic: counts converter ticks from trigger to completion.
   logic [3:0] chk_ticks_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_ticks_reg <= 4'h0;
      end else if (trigger && state_reg == ACS_IDLE) begin
         chk_ticks_reg <= 4'h0;
      end else if (state_reg != ACS_IDLE && tick && chk_ticks_reg != 4'hf) begin
         chk_ticks_reg <= chk_ticks_reg + 4'h1;
      end
   end

   a_total_ticks: assert property (@(posedge clk) disable iff (!rst_n)
      done |-> chk_ticks_reg == `ACS_TOTAL_TICKS - 4'h1)
      else $error("conversion did not take twelve converter clocks");

   a_sample_length: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_reg == ACS_CONVERT) |-> chk_ticks_reg == `ACS_SAMPLE_TICKS)
      else $error("sampling phase length wrong");

   a_start_busy: assert property (@(posedge clk) disable iff (!rst_n)
      trigger && state_reg == ACS_IDLE |=> state_reg == ACS_SAMPLE)
      else $error("start pulse did not begin a conversion");

   a_busy_cause: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_reg != ACS_IDLE) |-> $past(start_prev_reg) && !$past(start_reg))
      else $error("conversion began without a completed start pulse");

   a_done_flags: assert property (@(posedge clk) disable iff (!rst_n)
      done |=> state_reg == ACS_IDLE && irq_flag_reg && result_reg == $past(decided))
      else $error("completion did not clear busy and set flag and result");

   a_result_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !done |=> $stable(result_reg))
      else $error("result changed without a completion");

   a_disable_off: assert property (@(posedge clk) disable iff (!rst_n)
      !converter_enable_reg |=> state_reg == ACS_IDLE && !converter_power_on && !sample_enable)
      else $error("disabled converter still active");

   a_tick_steps: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == ACS_CONVERT && !tick && converter_enable_reg |=> $stable(bit_reg) && $stable(trial_reg))
      else $error("conversion advanced without a converter tick");

   a_irq_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      done |=> conversion_irq_pulse ##1 !conversion_irq_pulse)
      else $error("interrupt pulse not one cycle after completion");

   a_mux_decode: assert property (@(posedge clk) disable iff (!rst_n)
      converter_enable_reg && $stable(chan_reg) && chan_reg > `ACS_CHAN_LAST |=> !analog_input_valid)
      else $error("nonexistent channel routed to converter");

   a_no_stall: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg != ACS_IDLE && wr_pend_reg && addr_reg == `ACS_OFF_CTRL_A
      |=> hreadyout && !hresp && start_reg == $past(hwdata[`ACS_A_START]))
      else $error("bus stalled during conversion");

   c_conversion: cover property (@(posedge clk) disable iff (!rst_n) done);
   c_full_scale: cover property (@(posedge clk) disable iff (!rst_n) done && decided == 8'hff);
   c_abort: cover property (@(posedge clk) disable iff (!rst_n)
      state_reg != ACS_IDLE && !converter_enable_reg);
   c_irq_out: cover property (@(posedge clk) disable iff (!rst_n) $rose(conversion_irq_request));

endmodule : acs_top

`default_nettype wire
